/* File: sadc_pkg.sv */
// package: register map, field positions, reset values and carriers for the slope converter
package sadc_pkg;
	// register byte addresses (one aligned 32-bit word each)
	localparam logic [7:0] ctrl0_off     = 8'h00; // first_control_register
	localparam logic [7:0] ctrl1_off     = 8'h04; // second_control_register
	localparam logic [7:0] pwr_off       = 8'h08; // power_control_register
	localparam logic [7:0] cnt_hi_off    = 8'h0c; // ramp_counter_high
	localparam logic [7:0] cnt_lo_off    = 8'h10; // ramp_counter_low
	localparam logic [7:0] snap_hi_off   = 8'h14; // trip_snapshot_high
	localparam logic [7:0] snap_lo_off   = 8'h18; // trip_snapshot_low
	localparam logic [7:0] flags_off     = 8'h1c; // flags and enables

	// first_control_register fields
	localparam int         ctrl0_zero_bit  = 0;
	localparam int         ctrl0_hold_bit  = 1;
	localparam int         ctrl0_muxoe_bit = 2;
	localparam int         ctrl0_chan_lsb  = 4;
	localparam logic [7:0] ctrl0_rst       = 8'h02; // ramp_hold set
	localparam logic [7:0] ctrl0_mask      = 8'hf7; // bit 3 reads zero

	// second_control_register fields
	localparam int         ctrl1_dac_lsb   = 4;
	localparam logic [7:0] ctrl1_rst       = 8'h00;

	// power_control_register fields
	localparam int         pwr_conv_bit    = 0;
	localparam int         pwr_osc_bit     = 3;
	localparam int         pwr_ref_bit     = 5;
	localparam logic [7:0] pwr_rst         = 8'h3f; // bit 3 reads one, bit 6 zero
	localparam logic [7:0] pwr_mask        = 8'hbf;

	// flags register fields
	localparam int         flg_cap_bit     = 0;
	localparam int         flg_ovf_bit     = 1;
	localparam int         flg_cap_ie_bit  = 2;
	localparam int         flg_ovf_ie_bit  = 3;
	localparam int         flg_pie_bit     = 4;
	localparam int         flg_gie_bit     = 5;
	localparam logic [7:0] flags_rst       = 8'h00;

	localparam logic [15:0] cnt_rst        = 16'h0000;
	localparam logic [15:0] cnt_all_ones   = 16'hffff;

	// analog front end controls travel together
	typedef struct packed {
		logic [3:0] channel;
		logic [3:0] dac_code;
		logic       ramp_hold;
		logic       mux_out_en;
		logic       zero_en;
		logic       conv_off;
		logic       ref_off;
		logic [3:0] pin_cfg_hi;
		logic [3:0] pin_cfg_lo;
	} sadc_analog_type;

	// wishbone slave side
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} sadc_wb_req_type;
endpackage

/* File: sadc_timer_capture.sv */
// slope converter ramp counter, trip snapshot, flags and register slave
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps

// How it works
// RULE_01: 16-bit counter increments each cycle unless held
// RULE_02: every reset clears the counter to zero
// RULE_03: software reloads counter after each conversion
// RULE_04: separate 16-bit snapshot register takes count
// RULE_05: counter and snapshot bytes readable and writable
// RULE_06: low byte before high leaves counter stopped
// RULE_07: avoid counter access during conversion
// RULE_08: comparator falling edge captures count, sets flag
// RULE_09: capture irq needs three enables set
// RULE_10: one capture per conversion cycle
// RULE_11: software clears capture flag before next cycle
// RULE_12: counter wrap to zero sets overflow flag
// RULE_13: counter keeps running after overflow
// RULE_14: overflow irq needs three enables set
// RULE_15: software clears overflow flag before next cycle
// RULE_16: sleep clock kept when disable bit clear
// RULE_17: gated converter clock freezes the counter
// RULE_18: gated clock blocks flag; wake trip captures
// RULE_19: reset leaves converter off, pins analog
// RULE_20: upper nibble selects one of 16 channels
// RULE_21: ramp hold disconnects current source
// RULE_22: preset counter to choose resolution
// RULE_23: full conversion lasts 2^N cycles
// RULE_24: ramp hold stops counter, discharges capacitor
// RULE_25: power bits 0, 5, 3 disable when set
// RULE_26: snapshot keeps value until capture or write
module sadc_timer_capture
(
	input  wire logic                     ref_clk,
	input  wire logic                     rst_b,
	input  wire sadc_pkg::sadc_wb_req_type wb_req,
	output logic [31:0]                   wb_dat_o,
	output logic                          wb_ack_o,
	input  wire logic                     comp_out,
	input  wire logic                     sleep_mode,
	output logic                          irq,
	output sadc_pkg::sadc_analog_type     analog_ctl,
	output logic                          ramp_discharge
);
	import sadc_pkg::*;

	logic [15:0] cnt_ff;
	logic [15:0] snap_ff;
	logic [7:0]  ctrl0_ff;
	logic [7:0]  ctrl1_ff;
	logic [7:0]  pwr_ff;
	logic [7:0]  flags_ff;
	logic        cnt_armed_ff;
	logic        cnt_hi_seen_ff;
	logic        cap_done_ff;
	logic        comp_s1_ff;
	logic        comp_s2_ff;
	logic        comp_prev_ff;
	logic        trip_pend_ff;
	logic        ack_ff;
	logic [31:0] rdat_ff;

	// bus decode
	wire bus_req   = wb_req.cyc & wb_req.stb & ~ack_ff;
	wire bus_wr    = bus_req & wb_req.we & wb_req.sel[0];
	wire wr_ctrl0  = bus_wr && (wb_req.adr == ctrl0_off);
	wire wr_ctrl1  = bus_wr && (wb_req.adr == ctrl1_off);
	wire wr_pwr    = bus_wr && (wb_req.adr == pwr_off);
	wire wr_cnt_hi = bus_wr && (wb_req.adr == cnt_hi_off);
	wire wr_cnt_lo = bus_wr && (wb_req.adr == cnt_lo_off);
	wire wr_snp_hi = bus_wr && (wb_req.adr == snap_hi_off);
	wire wr_snp_lo = bus_wr && (wb_req.adr == snap_lo_off);
	wire wr_flags  = bus_wr && (wb_req.adr == flags_off);
	wire [7:0] wbyte = wb_req.dat[7:0];

	// clock gating and run conditions
	wire conv_clk_on = ~sleep_mode | ~pwr_ff[pwr_osc_bit];            // [RULE_16]
	wire hold        = ctrl0_ff[ctrl0_hold_bit];
	wire cnt_run     = conv_clk_on & ~hold & cnt_armed_ff;            // [RULE_01] [RULE_17] [RULE_24]
	wire wrap        = cnt_run && (cnt_ff == cnt_all_ones);           // [RULE_12] [RULE_23]

	// comparator trip, caught while the clock is gated and served on wake
	wire comp_fall   = comp_prev_ff & ~comp_s2_ff;                    // [RULE_08]
	wire trip_seen   = comp_fall | trip_pend_ff;
	wire capture     = trip_seen & conv_clk_on & ~hold & ~cap_done_ff; // [RULE_10] [RULE_18]

	// read mux
	logic [7:0] rsel;
	always_comb
	begin
		rsel = 8'h00;
		if (wb_req.adr == ctrl0_off)
			rsel = ctrl0_ff & ctrl0_mask;
		else if (wb_req.adr == ctrl1_off)
			rsel = ctrl1_ff;
		else if (wb_req.adr == pwr_off)
			rsel = pwr_ff & pwr_mask;
		else if (wb_req.adr == cnt_hi_off)
			rsel = cnt_ff[15:8];                                     // [RULE_05]
		else if (wb_req.adr == cnt_lo_off)
			rsel = cnt_ff[7:0];
		else if (wb_req.adr == snap_hi_off)
			rsel = snap_ff[15:8];
		else if (wb_req.adr == snap_lo_off)
			rsel = snap_ff[7:0];
		else if (wb_req.adr == flags_off)
			rsel = flags_ff;
	end

	// comparator synchroniser and edge history
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			comp_s1_ff   <= 1'b0;
			comp_s2_ff   <= 1'b0;
			comp_prev_ff <= 1'b0;
		end
		else
		begin
			comp_s1_ff   <= comp_out;
			comp_s2_ff   <= comp_s1_ff;
			comp_prev_ff <= comp_s2_ff;
		end
	end

	// ramp counter with byte writes
	logic [15:0] nxt_cnt;
	logic        nxt_armed;
	logic        nxt_hi_seen;
	always_comb
	begin
		nxt_cnt     = cnt_run ? 16'(cnt_ff + 16'h0001) : cnt_ff;    // [RULE_01] [RULE_13]
		nxt_armed   = cnt_armed_ff;
		nxt_hi_seen = cnt_hi_seen_ff;
		if (wr_cnt_hi)
		begin
			nxt_cnt[15:8] = wbyte;
			nxt_armed     = 1'b0;                                    // wait for low byte
			nxt_hi_seen   = 1'b1;
		end
		else if (wr_cnt_lo)
		begin
			nxt_cnt[7:0] = wbyte;
			nxt_armed    = cnt_hi_seen_ff;                           // [RULE_06]
			nxt_hi_seen  = 1'b0;                                     // a pair is used up
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_ff         <= cnt_rst;                               // [RULE_02]
			cnt_armed_ff   <= 1'b1;
			cnt_hi_seen_ff <= 1'b0;
		end
		else
		begin
			cnt_ff         <= nxt_cnt;
			cnt_armed_ff   <= nxt_armed;
			cnt_hi_seen_ff <= nxt_hi_seen;
		end
	end

	// snapshot register: capture beats a same-cycle write
	logic [15:0] nxt_snap;
	always_comb
	begin
		nxt_snap = snap_ff;                                          // [RULE_26]
		if (wr_snp_hi)
			nxt_snap[15:8] = wbyte;
		if (wr_snp_lo)
			nxt_snap[7:0] = wbyte;
		if (capture)
			nxt_snap = cnt_ff;                                       // [RULE_04] [RULE_08]
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			snap_ff <= cnt_rst;
		else
			snap_ff <= nxt_snap;
	end

	// flags: hardware set wins over software clear
	logic [7:0] nxt_flags;
	always_comb
	begin
		nxt_flags = wr_flags ? wbyte : flags_ff;
		if (capture)
			nxt_flags[flg_cap_bit] = 1'b1;                           // [RULE_08]
		if (wrap)
			nxt_flags[flg_ovf_bit] = 1'b1;                           // [RULE_12]
	end

	// one capture per conversion; hold (discharge) ends the cycle
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			flags_ff     <= flags_rst;
			cap_done_ff  <= 1'b0;
			trip_pend_ff <= 1'b0;
		end
		else
		begin
			flags_ff     <= nxt_flags;
			cap_done_ff  <= hold ? 1'b0 : (cap_done_ff | capture);   // [RULE_10]
			trip_pend_ff <= trip_seen & ~capture & ~hold;            // [RULE_18]
		end
	end

	// control registers
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl0_ff <= ctrl0_rst;                                   // [RULE_19] [RULE_24]
			ctrl1_ff <= ctrl1_rst;                                   // [RULE_19]
			pwr_ff   <= pwr_rst;                                     // [RULE_19] [RULE_25]
		end
		else
		begin
			if (wr_ctrl0)
				ctrl0_ff <= wbyte & ctrl0_mask;
			if (wr_ctrl1)
				ctrl1_ff <= wbyte;
			if (wr_pwr)
				pwr_ff <= wbyte & pwr_mask;
		end
	end

	// wishbone answer, one cycle after the request
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ack_ff  <= 1'b0;
			rdat_ff <= 32'h0000_0000;
		end
		else
		begin
			ack_ff  <= bus_req;
			rdat_ff <= bus_req ? {24'h00_0000, rsel} : 32'h0000_0000;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

	// interrupt request, gated by the three enables
	wire en_all  = flags_ff[flg_pie_bit] & flags_ff[flg_gie_bit];
	wire cap_irq = flags_ff[flg_cap_bit] & flags_ff[flg_cap_ie_bit] & en_all; // [RULE_09]
	wire ovf_irq = flags_ff[flg_ovf_bit] & flags_ff[flg_ovf_ie_bit] & en_all; // [RULE_14]
	assign irq   = cap_irq | ovf_irq;

	// analog front end controls
	assign analog_ctl.channel    = ctrl0_ff[ctrl0_chan_lsb +: 4];              // [RULE_20]
	assign analog_ctl.dac_code   = hold ? 4'h0 : ctrl1_ff[ctrl1_dac_lsb +: 4]; // [RULE_21]
	assign analog_ctl.ramp_hold  = hold;
	assign analog_ctl.mux_out_en = ctrl0_ff[ctrl0_muxoe_bit];
	assign analog_ctl.zero_en    = ctrl0_ff[ctrl0_zero_bit];
	assign analog_ctl.conv_off   = pwr_ff[pwr_conv_bit];                       // [RULE_25]
	assign analog_ctl.ref_off    = pwr_ff[pwr_ref_bit];
	assign analog_ctl.pin_cfg_hi = ctrl1_ff[3:0];
	assign analog_ctl.pin_cfg_lo = ctrl1_ff[3:0];
	assign ramp_discharge        = hold;                                       // [RULE_24]
endmodule

/* File: sadc_properties.sv */
// checker for the slope converter register slave and analog controls
`timescale 1ns/1ps
module sadc_properties
(
	input wire logic                      ref_clk,
	input wire logic                      rst_b,
	input wire sadc_pkg::sadc_wb_req_type wb_req,
	input wire logic [31:0]               wb_dat_o,
	input wire logic                      wb_ack_o,
	input wire logic                      comp_out,
	input wire logic                      sleep_mode,
	input wire logic                      irq,
	input wire sadc_pkg::sadc_analog_type analog_ctl,
	input wire logic                      ramp_discharge
);
	import sadc_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// bus request and answer steps
	sequence s_req_taken;
		wb_req.cyc && wb_req.stb && !wb_ack_o;
	endsequence
	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	sequence s_ctrl0_write;
		s_req_taken ##0 (wb_req.we && wb_req.sel[0] && wb_req.adr == ctrl0_off);
	endsequence
	a_channel_follows: assert property (s_ctrl0_write |=> analog_ctl.channel == $past(wb_req.dat[7:4]))
		else $error("channel select not taken from write");
	a_bus_answer: assert property (s_req_taken |=> s_ack_pulse)
		else $error("request not answered by one ack pulse");
	a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_req.cyc && wb_req.stb))
		else $error("ack without request");
	a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_upper_bytes_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bytes not zero");
	a_discharge_tracks: assert property (ramp_discharge == analog_ctl.ramp_hold)
		else $error("discharge differs from ramp hold");
	a_source_off_hold: assert property (analog_ctl.ramp_hold |-> analog_ctl.dac_code == 4'h0)
		else $error("current source on during hold");
	a_pin_cfg_pair: assert property (analog_ctl.pin_cfg_hi == analog_ctl.pin_cfg_lo)
		else $error("pin config halves differ");
	a_reset_state: assert property ($rose(rst_b) |-> analog_ctl.ramp_hold && analog_ctl.conv_off
		&& analog_ctl.ref_off && analog_ctl.pin_cfg_lo == 4'h0)
		else $error("converter not off after reset");
endmodule

bind sadc_timer_capture sadc_properties i_sadc_properties (.ref_clk(ref_clk), .rst_b(rst_b),
	.wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comp_out(comp_out),
	.sleep_mode(sleep_mode), .irq(irq), .analog_ctl(analog_ctl), .ramp_discharge(ramp_discharge));

/* File: sadc_comparator_model.sv */
// comparator on the ramp capacitor, falls once the ramp has run long enough
`timescale 1ns/1ps
module sadc_comparator_model
(
	input  wire logic        ref_clk,
	input  wire logic        ramp_discharge,
	input  wire logic [15:0] trip_after,
	output logic             comp_out
);
	logic [15:0] ramp_ff = 16'h0000;
	// ramp rises only while the source is connected, grounded on discharge
	always @(posedge ref_clk)
		ramp_ff <= ramp_discharge ? 16'h0000 : ramp_ff + {15'h0, ramp_ff != 16'hffff};
	// output high while ramp is below the input level
	assign comp_out = ramp_ff < trip_after;
endmodule

/* File: tb_sadc_timer_capture.sv */
// self-checking bench for the slope converter counter and capture block
`timescale 1ns/1ps
module tb_sadc_timer_capture;
	import sadc_pkg::*;
	logic            ref_clk    = 1'b0;
	logic            rst_b      = 1'b0;
	logic            sleep_mode = 1'b0;
	sadc_wb_req_type wb_req     = '0;
	logic [31:0]     wb_dat_o;
	logic            wb_ack_o;
	logic            comp_out;
	logic            irq;
	logic            ramp_discharge;
	sadc_analog_type analog_ctl;
	int              failures   = 0;
	int              num_checks = 0;
	int              cycles     = 0;
	logic [7:0]      q;
	logic [7:0]      q2;
	always #5 ref_clk = ~ref_clk;
	sadc_timer_capture i_sadc_timer_capture (.ref_clk(ref_clk), .rst_b(rst_b), .wb_req(wb_req),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comp_out(comp_out), .sleep_mode(sleep_mode),
		.irq(irq), .analog_ctl(analog_ctl), .ramp_discharge(ramp_discharge));
	sadc_comparator_model i_sadc_comparator_model (.ref_clk(ref_clk),
		.ramp_discharge(ramp_discharge), .trip_after(16'd100), .comp_out(comp_out));
	task automatic finish_test;
		if (failures == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one classic cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
		@(posedge ref_clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h1, adr: a, dat: {24'h0, d}};
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		r = wb_dat_o[7:0];
		wb_req <= '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00, q);
		check(n, q, exp);
	endtask
	// hang guard
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			finish_test();
		end
	end
	// main sequence
	initial
	begin
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		rdc("ctrl0", ctrl0_off, ctrl0_rst);
		check("discharge", ramp_discharge, 1'b1);
		rdc("power", pwr_off, pwr_rst);
		rdc("ctrl1", ctrl1_off, 8'h00);
		rdc("cnt_lo", cnt_lo_off, 8'h00);
		rdc("cnt_hi", cnt_hi_off, 8'h00);
		wr(8'h20, 8'h55);
		rdc("unmapped", 8'h20, 8'h00);
		rdc("flags", flags_off, 8'h00);
		wr(ctrl1_off, 8'h93);
		check("dac_held", {12'h0, analog_ctl.dac_code}, 16'h0000);
		check("pin_cfg", {12'h0, analog_ctl.pin_cfg_lo}, 16'h0003);
		for (int c = 0; c < 16; c++)
		begin
			wr(ctrl0_off, {c[3:0], 4'h2});
			check("channel", {12'h0, analog_ctl.channel}, c[15:0]);
		end
		wr(snap_hi_off, 8'ha5);
		wr(snap_lo_off, 8'h3c);
		rdc("snap_hi", snap_hi_off, 8'ha5);
		rdc("snap_lo", snap_lo_off, 8'h3c);
		wr(pwr_off, 8'h00);
		check("pwr_on", {14'h0, analog_ctl.conv_off, analog_ctl.ref_off}, 16'h0000);
		wr(cnt_hi_off, 8'hff);
		wr(cnt_lo_off, 8'hf0);
		wr(ctrl0_off, 8'h00);
		repeat (40) @(posedge ref_clk);
		wr(ctrl0_off, 8'h02);
		rdc("cnt_hi_wrap", cnt_hi_off, 8'h00);
		rdc("flags_ovf", flags_off, 8'h02);
		wr(flags_off, 8'h3a);
		check("irq_ovf", irq, 1'b1);
		wr(flags_off, 8'h1a);
		check("irq_no_gie", irq, 1'b0);
		wr(flags_off, 8'h34);
		wr(cnt_hi_off, 8'h10);
		wr(cnt_lo_off, 8'h00);
		wr(ctrl0_off, 8'h00);
		check("dac_run", {12'h0, analog_ctl.dac_code}, 16'h0009);
		repeat (120) @(posedge ref_clk);
		check("irq_cap", irq, 1'b1);
		rdc("flags_cap", flags_off, 8'h35);
		rdc("snap_hi_cap", snap_hi_off, 8'h10);
		bus(1'b0, snap_lo_off, 8'h00, q2);
		check("snap_lo_cap", q2 >= 8'd100 && q2 <= 8'd106, 1'b1);
		repeat (20) @(posedge ref_clk);
		rdc("snap_kept", snap_lo_off, q2);
		wr(ctrl0_off, 8'h02);
		wr(flags_off, 8'h00);
		wr(cnt_lo_off, 8'h00);
		wr(ctrl0_off, 8'h00);
		repeat (10) @(posedge ref_clk);
		rdc("cnt_stopped", cnt_lo_off, 8'h00);
		wr(cnt_lo_off, 8'h00);
		repeat (5) @(posedge ref_clk);
		rdc("cnt_still_stopped", cnt_lo_off, 8'h00);
		wr(cnt_hi_off, 8'h00);
		wr(cnt_lo_off, 8'h00);
		sleep_mode <= 1'b1;
		repeat (10) @(posedge ref_clk);
		bus(1'b0, cnt_lo_off, 8'h00, q);
		check("sleep_runs", q > 8'h08, 1'b1);
		wr(pwr_off, 8'h08);
		bus(1'b0, cnt_lo_off, 8'h00, q2);
		repeat (10) @(posedge ref_clk);
		rdc("sleep_frozen", cnt_lo_off, q2);
		finish_test();
	end
endmodule
